// file: logic/htp_probe_reader.v
`timescale 1ns/1ps
`include "htp_defs.vh"
module htp_probe_reader #(
  parameter ALT_LINES = 0,
  parameter MEAS_TIMEOUT = `HTP_MEAS_TIMEOUT_MS * `HTP_CLK_KHZ
) (
  input wire clk,
  input wire rst_n,
  input wire regRd,
  input wire regWr,
  input wire [15:0] regAddr,
  input wire [15:0] regWrData,
  output wire [31:0] regRdData,
  output wire regRdValid,
  output wire regRdErr,
  output wire regBusy,
  input wire [22:0] dioIn,
  output reg [22:0] dioOut,
  output reg [22:0] dioOe
);
  localparam [15:0] DEF_DATA = ALT_LINES ? `HTP_DEF_DATA_ALT : `HTP_DEF_DATA;
  localparam [15:0] DEF_CLK = ALT_LINES ? `HTP_DEF_CLK_ALT : `HTP_DEF_CLK;
  localparam [15:0] DEF_POWER = ALT_LINES ? `HTP_DEF_POWER_ALT : `HTP_DEF_POWER;
  localparam [3:0] S_IDLE = 4'h0, S_PWR = 4'h1, S_ENA = 4'h2, S_START = 4'h3,
    S_CMD = 4'h4, S_ACK = 4'h5, S_WAIT = 4'h6, S_RD = 4'h7, S_MACK = 4'h8,
    S_DIS = 4'h9, S_CHK = 4'hA, S_CONV = 4'hB;

  function [7:0] crcBit;
    input [7:0] crc;
    input b;
    begin
      crcBit = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? `HTP_CRC_POLY : 8'h00);
    end
  endfunction

  function [7:0] rev8;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) rev8[k] = v[7 - k];
    end
  endfunction

  reg [15:0] dataSel_q [0:22];
  reg [15:0] clkSel_q [0:22];
  reg [15:0] powerSel_q, speed_q;
  reg [22:0] dioS1_q, dioS2_q, enOe_q, enLvl_q;
  reg [3:0] state_q, step_q;
  reg [2:0] bitCnt_q;
  reg [1:0] byteCnt_q;
  reg phase_q, isRh_q, err_q, dataLow_q, sclk_q, lineOwn_q, powerOn_q, enCtl_q;
  reg [4:0] chan_q;
  reg [7:0] cmd_q, crc_q;
  reg [23:0] rx_q;
  reg [17:0] divCnt_q;
  reg [31:0] waitCnt_q, rdData_q;
  reg rdValid_q, rdErr_q;
  integer i, j, p;

  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;
  assign regRdErr = rdErr_q;
  assign regBusy = (state_q != S_IDLE);

  // Bit clock half-period from speed setting
  wire [16:0] spdEff = (speed_q == 16'h0000) ? 17'h10000 : {1'b0, speed_q};
  wire [17:0] stepPart = {1'b0, 17'h10000 - spdEff} * `HTP_SPEED_STEP;
  wire [31:0] halfSum = stepPart + `HTP_HALF_BASE;
  wire [17:0] halfCyc = halfSum[17:0];
  wire tick = (divCnt_q == 18'h00000);

  wire [15:0] curData = dataSel_q[chan_q];
  wire [15:0] curClk = clkSel_q[chan_q];
  wire dataValid = (curData < `HTP_NUM_CH);
  wire dataIn = dataValid ? dioS2_q[curData[4:0]] : 1'b1;

  // Address decode
  wire [15:0] offT = regAddr - `HTP_TEMP_BASE;
  wire [15:0] offH = regAddr - `HTP_RH_BASE;
  wire [15:0] offD = regAddr - `HTP_DATA_BASE;
  wire [15:0] offC = regAddr - `HTP_CLK_BASE;
  wire hitT = (regAddr >= `HTP_TEMP_BASE) && (offT < `HTP_NUM_CH);
  wire hitH = (regAddr >= `HTP_RH_BASE) && (offH < `HTP_NUM_CH);
  wire hitD = (regAddr >= `HTP_DATA_BASE) && (offD < `HTP_NUM_CH);
  wire hitC = (regAddr >= `HTP_CLK_BASE) && (offC < `HTP_NUM_CH);
  wire idle = (state_q == S_IDLE);

  // Global read: common value or mixed marker
  reg sameD, sameC;
  always @* begin
    sameD = 1'b1;
    sameC = 1'b1;
    for (j = 1; j < 23; j = j + 1) begin
      if (dataSel_q[j] != dataSel_q[0]) sameD = 1'b0;
      if (clkSel_q[j] != clkSel_q[0]) sameC = 1'b0;
    end
  end

  // Raw to fixed point physical value
  reg [39:0] tFix, fix;
  reg [47:0] rhS, rhPos, rhNeg;
  always @* begin
    tFix = `HTP_T_OFS + {26'h0, rx_q[21:8]} * `HTP_T_GAIN;
    rhS = {36'h0, rx_q[19:8]};
    rhPos = rhS * `HTP_RH_C2;
    rhNeg = ((rhS * rhS * `HTP_RH_C3) >> 16) + `HTP_RH_C1;
    if (!isRh_q) fix = tFix;
    else if (rhPos > rhNeg) fix = rhPos[39:0] - rhNeg[39:0];
    else fix = 40'h0000000000;
  end

  wire [31:0] flt;
  htp_fix_to_float uConv (
    .fixIn(fix),
    .fltOut(flt)
  );

  // Pin drive: enable, power, clock, data in rising priority
  always @* begin
    for (p = 0; p < 23; p = p + 1) begin
      dioOe[p] = enOe_q[p];
      dioOut[p] = enLvl_q[p];
      if (powerSel_q == p[15:0] && powerOn_q) begin
        dioOe[p] = 1'b1;
        dioOut[p] = 1'b1;
      end
      if (lineOwn_q && curClk == p[15:0]) begin
        dioOe[p] = 1'b1;
        dioOut[p] = sclk_q;
      end
      if (lineOwn_q && curData == p[15:0]) begin
        dioOe[p] = dataLow_q;
        dioOut[p] = 1'b0;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 23; i = i + 1) begin
        dataSel_q[i] <= DEF_DATA;
        clkSel_q[i] <= DEF_CLK;
      end
      powerSel_q <= DEF_POWER;
      speed_q <= `HTP_DEF_SPEED;
      dioS1_q <= 23'h000000;
      dioS2_q <= 23'h000000;
      enOe_q <= 23'h000000;
      enLvl_q <= 23'h000000;
      state_q <= S_IDLE;
      step_q <= 4'h0;
      bitCnt_q <= 3'h0;
      byteCnt_q <= 2'h0;
      phase_q <= 1'b0;
      isRh_q <= 1'b0;
      err_q <= 1'b0;
      dataLow_q <= 1'b0;
      sclk_q <= 1'b0;
      lineOwn_q <= 1'b0;
      powerOn_q <= 1'b1;
      enCtl_q <= 1'b0;
      chan_q <= 5'h00;
      cmd_q <= 8'h00;
      crc_q <= 8'h00;
      rx_q <= 24'h000000;
      divCnt_q <= 18'h00000;
      waitCnt_q <= 32'h00000000;
      rdData_q <= 32'h00000000;
      rdValid_q <= 1'b0;
      rdErr_q <= 1'b0;
    end else begin
      dioS1_q <= dioIn;
      dioS2_q <= dioS1_q;
      rdValid_q <= 1'b0;
      rdErr_q <= 1'b0;
      if (idle || tick) divCnt_q <= halfCyc - 18'h00001;
      else divCnt_q <= divCnt_q - 18'h00001;
      case (state_q)
        S_IDLE: begin
          if (regRd && (hitT || hitH)) begin
            chan_q <= hitT ? offT[4:0] : offH[4:0];
            isRh_q <= hitH;
            cmd_q <= hitH ? `HTP_CMD_RH : `HTP_CMD_TEMP;
            err_q <= 1'b0;
            crc_q <= 8'h00;
            state_q <= S_PWR;
          end else if (regRd) begin
            rdValid_q <= 1'b1;
            if (hitD) rdData_q <= {16'h0000, dataSel_q[offD[4:0]]};
            else if (hitC) rdData_q <= {16'h0000, clkSel_q[offC[4:0]]};
            else if (regAddr == `HTP_ALL_DATA)
              rdData_q <= {16'h0000, sameD ? dataSel_q[0] : `HTP_MIXED};
            else if (regAddr == `HTP_ALL_CLK)
              rdData_q <= {16'h0000, sameC ? clkSel_q[0] : `HTP_MIXED};
            else if (regAddr == `HTP_POWER_SEL) rdData_q <= {16'h0000, powerSel_q};
            else if (regAddr == `HTP_SPEED) rdData_q <= {16'h0000, speed_q};
            else begin
              rdData_q <= 32'h00000000;
              rdErr_q <= 1'b1;
            end
          end else if (regWr) begin
            if (hitD) dataSel_q[offD[4:0]] <= regWrData;
            if (hitC) clkSel_q[offC[4:0]] <= regWrData;
            for (i = 0; i < 23; i = i + 1) begin
              if (regAddr == `HTP_ALL_DATA) dataSel_q[i] <= regWrData;
              if (regAddr == `HTP_ALL_CLK) clkSel_q[i] <= regWrData;
            end
            if (regAddr == `HTP_POWER_SEL) powerSel_q <= regWrData;
            if (regAddr == `HTP_SPEED) speed_q <= regWrData;
          end
        end
        S_PWR: begin
          powerOn_q <= 1'b1;
          lineOwn_q <= 1'b1;
          sclk_q <= 1'b0;
          dataLow_q <= 1'b0;
          enCtl_q <= ({11'h000, chan_q} != curData) && ({11'h000, chan_q} != curClk);
          state_q <= S_ENA;
        end
        S_ENA: begin
          if (enCtl_q) begin
            enOe_q[chan_q] <= 1'b1;
            enLvl_q[chan_q] <= 1'b1;
          end
          step_q <= 4'h0;
          state_q <= S_START;
        end
        S_START: if (tick) begin
          step_q <= step_q + 4'h1;
          case (step_q)
            4'h1: sclk_q <= 1'b1;
            4'h2: dataLow_q <= 1'b1;
            4'h3: sclk_q <= 1'b0;
            4'h4: sclk_q <= 1'b1;
            4'h5: dataLow_q <= 1'b0;
            4'h6: begin
              sclk_q <= 1'b0;
              dataLow_q <= ~cmd_q[7];
              bitCnt_q <= 3'h0;
              phase_q <= 1'b0;
              state_q <= S_CMD;
            end
            default: sclk_q <= 1'b0;
          endcase
        end
        S_CMD: if (tick) begin
          phase_q <= ~phase_q;
          sclk_q <= ~phase_q;
          if (phase_q) begin
            crc_q <= crcBit(crc_q, cmd_q[7]);
            cmd_q <= {cmd_q[6:0], 1'b0};
            bitCnt_q <= bitCnt_q + 3'h1;
            dataLow_q <= ~cmd_q[6];
            if (bitCnt_q == 3'h7) begin
              dataLow_q <= 1'b0;
              state_q <= S_ACK;
            end
          end
        end
        S_ACK: if (tick) begin
          phase_q <= ~phase_q;
          sclk_q <= ~phase_q;
          if (phase_q) begin
            waitCnt_q <= 32'h00000000;
            if (dataIn) begin
              err_q <= 1'b1;
              state_q <= S_DIS;
            end else state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          waitCnt_q <= waitCnt_q + 32'h00000001;
          if (tick && !dataIn) begin
            byteCnt_q <= 2'h0;
            bitCnt_q <= 3'h0;
            state_q <= S_RD;
          end else if (waitCnt_q >= MEAS_TIMEOUT) begin
            err_q <= 1'b1;
            state_q <= S_DIS;
          end
        end
        S_RD: if (tick) begin
          phase_q <= ~phase_q;
          sclk_q <= ~phase_q;
          if (phase_q) begin
            rx_q <= {rx_q[22:0], dataIn};
            if (byteCnt_q != 2'h2) crc_q <= crcBit(crc_q, dataIn);
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              dataLow_q <= (byteCnt_q != 2'h2);
              state_q <= S_MACK;
            end
          end
        end
        S_MACK: if (tick) begin
          phase_q <= ~phase_q;
          sclk_q <= ~phase_q;
          if (phase_q) begin
            dataLow_q <= 1'b0;
            byteCnt_q <= byteCnt_q + 2'h1;
            state_q <= (byteCnt_q == 2'h2) ? S_DIS : S_RD;
          end
        end
        S_DIS: begin
          sclk_q <= 1'b0;
          dataLow_q <= 1'b0;
          if (enCtl_q) enLvl_q[chan_q] <= 1'b0;
          state_q <= S_CHK;
        end
        S_CHK: begin
          if (err_q || rev8(crc_q) != rx_q[7:0]) begin
            rdValid_q <= 1'b1;
            rdErr_q <= 1'b1;
            rdData_q <= 32'h00000000;
            state_q <= S_IDLE;
          end else state_q <= S_CONV;
        end
        S_CONV: begin
          rdData_q <= flt;
          rdValid_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // htp_probe_reader

// file: logic/htp_defs.vh
`ifndef HTP_DEFS_VH
`define HTP_DEFS_VH
// Register offsets
`define HTP_TEMP_BASE 16'h7594
`define HTP_RH_BASE 16'h75C6
`define HTP_DATA_BASE 16'h75F8
`define HTP_CLK_BASE 16'h7611
`define HTP_ALL_DATA 16'h7643
`define HTP_ALL_CLK 16'h7644
`define HTP_POWER_SEL 16'h7645
`define HTP_SPEED 16'h7646
`define HTP_NUM_CH 16'h0017
`define HTP_MIXED 16'h00FF
// Reset values
`define HTP_DEF_DATA 16'h0004
`define HTP_DEF_CLK 16'h0005
`define HTP_DEF_POWER 16'h0006
`define HTP_DEF_DATA_ALT 16'h0000
`define HTP_DEF_CLK_ALT 16'h0001
`define HTP_DEF_POWER_ALT 16'h0002
`define HTP_DEF_SPEED 16'h0000
// Sensor commands
`define HTP_CMD_TEMP 8'h03
`define HTP_CMD_RH 8'h05
`define HTP_CRC_POLY 8'h31
// Timing
`define HTP_CLK_NS 40
`define HTP_CLK_KHZ 25000
`define HTP_FAST_PERIOD_NS 5000
`define HTP_HALF_BASE (`HTP_FAST_PERIOD_NS / `HTP_CLK_NS / 2)
`define HTP_SPEED_STEP 18'h00002
`define HTP_MEAS_TIMEOUT_MS 400
// Conversion constants, Q16 fixed point except HTP_RH_C3, which is Q32
`define HTP_T_OFS 40'h0000E97333
`define HTP_T_GAIN 40'h000000028F
`define HTP_RH_C1 48'h000000020BFB
`define HTP_RH_C2 48'h000000000965
`define HTP_RH_C3 48'h000000001AC5
`endif

// file: logic/htp_fix_to_float.v
`timescale 1ns/1ps
`include "htp_defs.vh"
module htp_fix_to_float (
  input wire [39:0] fixIn,
  output reg [31:0] fltOut
);
  integer i;
  reg [5:0] msb;
  reg [39:0] norm;
  reg [7:0] expo;
  always @* begin
    msb = 6'h00;
    for (i = 0; i < 40; i = i + 1) begin
      if (fixIn[i]) msb = i[5:0];
    end
    norm = fixIn << (6'h27 - msb);
    expo = {2'h0, msb} + 8'h6F;
    if (fixIn == 40'h0000000000) fltOut = 32'h00000000;
    else fltOut = {1'b0, expo, norm[38:16]};
  end
endmodule // htp_fix_to_float

// file: tb/htp_probe_reader_props.sv
`timescale 1ns/1ps
module htp_probe_reader_props #(
  parameter MEAS_TIMEOUT = 2000
) (
  input wire clk,
  input wire rst_n,
  input wire regRd,
  input wire regWr,
  input wire [15:0] regAddr,
  input wire [15:0] regWrData,
  input wire [31:0] regRdData,
  input wire regRdValid,
  input wire regRdErr,
  input wire regBusy,
  input wire [22:0] dioIn,
  input wire [22:0] dioOut,
  input wire [22:0] dioOe
);
  wire tempHit = regAddr >= 16'h7594 && regAddr <= 16'h75AA;
  wire isSens = tempHit || (regAddr >= 16'h75C6 && regAddr <= 16'h75DC);
  reg [4:0] chQ;
  reg sensQ;
  integer busyCnt;
  wire enOk = sensQ && chQ != 5'h04 && chQ != 5'h05;
  // Remember which probe the running transaction serves
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sensQ <= 1'b0;
      chQ <= 5'h00;
      busyCnt <= 0;
    end else begin
      busyCnt <= regBusy ? busyCnt + 1 : 0;
      if (regRd && !regBusy && isSens) begin
        sensQ <= 1'b1;
        chQ <= tempHit ? regAddr[4:0] - 5'h14 : regAddr[4:0] - 5'h06;
      end else if (regRdValid)
        sensQ <= 1'b0;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence takeSens;
    regRd && !regBusy && isSens;
  endsequence
  sequence goodEnd;
    regRdValid && !regRdErr && enOk;
  endsequence
  busy_start_a: assert property (
    takeSens |=> regBusy) else $error("busy did not rise");
  power_on_a: assert property (
    regBusy |-> dioOe[6] && dioOut[6]) else $error("power line not high");
  quick_answer_a: assert property (
    regRd && !regBusy && !isSens |=> regRdValid && !regBusy) else $error("late answer");
  err_valid_a: assert property (
    regRdErr |-> regRdValid) else $error("error without answer");
  enable_on_a: assert property (
    regBusy && $rose(dioOut[5]) && enOk |-> dioOe[chQ] && dioOut[chQ])
    else $error("enable low while clocking");
  enable_off_a: assert property (
    goodEnd |-> dioOe[chQ] && !dioOut[chQ]) else $error("enable not low at end");
  lines_kept_a: assert property (
    $fell(regBusy) |-> dioOe[5]) else $error("clock line released");
  busy_bound_a: assert property (
    busyCnt < MEAS_TIMEOUT + 16000) else $error("transaction never ends");
endmodule // htp_probe_reader_props

bind htp_probe_reader htp_probe_reader_props #(.MEAS_TIMEOUT(MEAS_TIMEOUT)) u_props (
  .clk(clk), .rst_n(rst_n), .regRd(regRd), .regWr(regWr), .regAddr(regAddr),
  .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
  .regRdErr(regRdErr), .regBusy(regBusy), .dioIn(dioIn), .dioOut(dioOut), .dioOe(dioOe));

// file: tb/htp_sensor_model.sv
`timescale 1ns/1ps
module htp_sensor_model (
  input wire [22:0] dioOe,
  input wire [22:0] dioOut,
  input wire [15:0] raw,
  input wire [31:0] waitNs,
  input wire noAck,
  input wire badCrc,
  output reg [7:0] cmd,
  output reg sensLow
);
  wire sck = dioOe[5] ? dioOut[5] : 1'b1;
  wire dat = !(dioOe[4] || sensLow);
  reg [26:0] frame;
  reg [7:0] crc;
  reg [7:0] rev;
  reg [23:0] dw;
  integer n = 99;
  integer m = 99;
  integer i;
  initial sensLow = 1'b0;
  // Data falling while clock high opens a frame
  always @(negedge dat)
    if (sck)
      n = -1;
  always @(posedge sck) begin
    if (n >= 0 && n < 8)
      cmd = {cmd[6:0], dat};
    if (n < 9)
      n = n + 1;
  end
  // Answer changes only while clock is low
  always @(negedge sck) begin
    if (n == 8 && !noAck)
      sensLow = 1'b1;
    if (n == 9) begin
      sensLow = 1'b0;
      n = 99;
      if (!noAck) begin
        #(waitNs);
        dw = {cmd, raw};
        crc = 8'h00;
        for (i = 23; i >= 0; i = i - 1)
          crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ dw[i]) ? 8'h31 : 8'h00);
        for (i = 0; i < 8; i = i + 1)
          rev[i] = crc[7 - i];
        frame = {raw[15:8], 1'b1, raw[7:0], 1'b1, rev ^ {7'h00, badCrc}, 1'b1};
        m = 0;
        sensLow = !frame[26];
      end
    end else if (m < 27) begin
      m = m + 1;
      sensLow = m < 27 && !frame[26 - m];
    end
  end
endmodule // htp_sensor_model

// file: tb/htp_probe_reader_tb.sv
`timescale 1ns/1ps
`include "htp_defs.vh"
module htp_probe_reader_tb;
  reg clk = 1'b0, rst_n = 1'b0, regRd = 1'b0, regWr = 1'b0, noAck = 1'b0, badCrc = 1'b0;
  reg [15:0] regAddr = 16'h0000, regWrData = 16'h0000, raw = 16'h1770;
  reg [31:0] waitNs = 32'h00002710;
  wire [31:0] regRdData;
  wire regRdValid, regRdErr, regBusy, sensLow;
  wire [22:0] dioOut, dioOe;
  wire [7:0] cmd;
  wire [22:0] drv = dioOut | ~dioOe;
  wire datW = !(dioOe[4] || sensLow);
  wire [22:0] dioIn = {drv[22:5], datW, drv[3:0]};
  wire sck = dioOe[5] && dioOut[5];
  integer miscompares = 0, checked = 0, hiRun = 0, hiLen = 0, i;
  reg [31:0] rdData;
  reg rdErr;
  reg [35:0] rows [0:6];
  htp_probe_reader #(.ALT_LINES(0), .MEAS_TIMEOUT(2000)) u_dut (
    .clk(clk), .rst_n(rst_n), .regRd(regRd), .regWr(regWr), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .regRdErr(regRdErr), .regBusy(regBusy), .dioIn(dioIn), .dioOut(dioOut), .dioOe(dioOe));
  htp_sensor_model u_probe (.dioOe(dioOe), .dioOut(dioOut), .raw(raw), .waitNs(waitNs),
    .noAck(noAck), .badCrc(badCrc), .cmd(cmd), .sensLow(sensLow));
  always #20 clk = ~clk;
  // Length of the last bit clock high phase
  always @(posedge clk) begin
    if (sck)
      hiRun <= hiRun + 1;
    else if (hiRun > 0) begin
      hiLen <= hiRun;
      hiRun <= 0;
    end
  end
  task give_verdict;
    begin
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input [79:0] what);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wrReg(input [15:0] a, input [15:0] d);
    begin
      regAddr = a;
      regWrData = d;
      regWr = 1'b1;
      @(posedge clk);
      #1 regWr = 1'b0;
    end
  endtask
  task rdReg(input [15:0] a);
    integer n;
    begin
      regAddr = a;
      regRd = 1'b1;
      @(posedge clk);
      #1 regRd = 1'b0;
      n = 0;
      while (n < 30000 && regRdValid !== 1'b1) begin
        @(posedge clk);
        #1 n = n + 1;
      end
      rdData = regRdData;
      rdErr = regRdErr;
      if (n == 30000) begin
        miscompares = miscompares + 1;
        give_verdict;
      end
    end
  endtask
  task sensRd(input [15:0] a, input [31:0] expD, input expE);
    begin
      rdReg(a);
      chk({31'h0, rdErr}, {31'h0, expE}, "error");
      if (!expE)
        chk(rdData, expD, "result");
      $display("test read %h done", a);
    end
  endtask
  function [31:0] toFlt(input [39:0] v);
    integer p;
    reg [63:0] s;
    begin
      p = 39;
      while (p > 0 && !v[p])
        p = p - 1;
      s = {24'h0, v} << (63 - p);
      toFlt = (v == 40'h0) ? 32'h00000000 : {1'b0, 8'h6F + p[7:0], s[62:40]};
    end
  endfunction
  initial begin
    rows[0] = 36'h7645_0_0006;
    rows[1] = 36'h7643_0_0004;
    rows[2] = 36'h7644_0_0005;
    rows[3] = 36'h75F8_0_0004;
    rows[4] = 36'h7611_0_0005;
    rows[5] = 36'h7646_0_0000;
    rows[6] = 36'h7000_1_0000;
    @(posedge clk);
    #1;
    chk({28'h0, dioOe[6], dioOut[6], regBusy, regRdValid}, 32'h0000000C, "reset");
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      rdReg(rows[i][35:20]);
      chk(rdData, {16'h0, rows[i][15:0]}, "table");
      chk({31'h0, rdErr}, {31'h0, rows[i][16]}, "table err");
    end
    $display("test table done");
    wrReg(16'h7645, 16'h270F);
    chk({30'h0, dioOe[6], dioOut[6]}, 32'h00000000, "no power");
    @(posedge clk);
    #1 wrReg(16'h7645, 16'h0006);
    $display("test power disable done");
    sensRd(16'h759B, toFlt(`HTP_T_OFS + `HTP_T_GAIN * raw), 1'b0);
    chk({24'h0, cmd}, 32'h00000003, "command");
    chk({30'h0, dioOe[7], dioOut[7]}, 32'h00000002, "enable");
    chk({31'h0, dioOe[5]}, 32'h00000001, "clk line");
    chk(hiLen, 32'h0000003E, "half");
    raw = 16'h0000;
    sensRd(16'h75DC, 32'h00000000, 1'b0);
    chk({24'h0, cmd}, 32'h00000005, "command");
    chk({30'h0, dioOe[22], dioOut[22]}, 32'h00000002, "enable");
    raw = 16'h1770;
    sensRd(16'h7598, toFlt(`HTP_T_OFS + `HTP_T_GAIN * raw), 1'b0);
    wrReg(16'h75F9, 16'h0008);
    rdReg(16'h7643);
    chk(rdData, 32'h000000FF, "mixed");
    wrReg(16'h7643, 16'h0004);
    rdReg(16'h75F9);
    chk(rdData, 32'h00000004, "all data");
    badCrc = 1'b1;
    sensRd(16'h759B, 32'h00000000, 1'b1);
    badCrc = 1'b0;
    noAck = 1'b1;
    sensRd(16'h759B, 32'h00000000, 1'b1);
    noAck = 1'b0;
    wrReg(16'h7646, 16'hFFFF);
    sensRd(16'h759B, toFlt(`HTP_T_OFS + `HTP_T_GAIN * raw), 1'b0);
    chk(hiLen, 32'h00000040, "half slow");
    waitNs = 32'h00030D40;
    sensRd(16'h759B, 32'h00000000, 1'b1);
    regAddr = 16'h759B;
    regRd = 1'b1;
    @(posedge clk);
    #1 regRd = 1'b0;
    repeat (100) @(posedge clk);
    #1;
    chk({31'h0, regBusy}, 32'h00000001, "busy mid");
    rst_n = 1'b0;
    #1;
    chk({28'h0, dioOe[6], dioOut[6], regBusy, regRdValid}, 32'h0000000C, "mid reset");
    @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1;
    chk({28'h0, dioOe[6], dioOut[6], regBusy, regRdValid}, 32'h0000000C, "after rst");
    $display("test mid reset done");
    give_verdict;
  end
endmodule // htp_probe_reader_tb
